/* hdl/ipd_decoder.sv */
// opcode stream parser with indexed postbyte decode
`timescale 1ns/10ps

// Functional notes
// - postbyte then zero, one or two extensions
// - rr0nnnnn is signed 5-bit offset, no extension
// - 111rr0zs with z=s=1 is indirect form
// - 111rr011 adds 16-bit constant then fetches pointer
// - rr1pnnnn auto update, p selects pre/post
// - auto update base only X, Y or SP
// - 111rr1aa adds A, B or D unsigned
// - 111rr111 adds D then fetches pointer
// - 8-bit opcode fixes operation and mode
// - prefix 18 selects second opcode page
// - postbyte accepted for indexed and other ops
// - extension bytes carry address, offset or data
// - 9-bit form takes one extension byte
// - 16-bit forms take two extension bytes
module ipd_decoder (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // byte stream from the fetch queue
    input  wire logic               byte_valid,
    input  wire logic [7:0]         byte_data,
    output logic                    byte_ready,
    // opcode classification lookup, same clock, combinational outside
    output logic [7:0]              lookup_opcode,
    output logic                    lookup_page2,
    input  wire ipd_pkg::ipd_pbkind_t lookup_pbkind,
    input  wire logic [1:0]         lookup_ext_count,
    // decoded instruction to address generation
    output logic                    instr_valid,
    output logic                    instr_page2,
    output logic [7:0]              instr_opcode,
    output logic                    instr_has_postbyte,
    output logic [7:0]              instr_postbyte,
    output ipd_pkg::ipd_form_t      instr_form,
    output ipd_pkg::ipd_base_t      instr_base,
    output ipd_pkg::ipd_acc_t       instr_accum,
    output logic                    instr_update_post,
    output logic [15:0]             instr_offset,
    output logic [1:0]              instr_ext_count,
    output logic [15:0]             instr_ext_data
);

    // ------------------------------------------------------------------
    // state record
    // ------------------------------------------------------------------
    typedef struct packed {
        ipd_pkg::ipd_state_t  st;          // parser state
        logic                 page2;       // prefix seen for this instruction
        logic [7:0]           opcode;      // latched opcode
        ipd_pkg::ipd_pbkind_t pbkind;      // latched postbyte kind
        logic [1:0]           op_ext;      // extensions from the opcode lookup
        logic [7:0]           postbyte;    // latched postbyte
        ipd_pkg::ipd_form_t   form;        // latched indexed form
        ipd_pkg::ipd_base_t   base;        // latched base register
        ipd_pkg::ipd_acc_t    accum;       // latched accumulator
        logic                 upd_post;    // latched pre/post choice
        logic                 sign9;       // latched ninth offset bit
        logic [15:0]          short_off;   // latched short offset
        logic [1:0]           ext_total;   // extensions expected
        logic [1:0]           ext_left;    // extensions still to come
        logic [15:0]          ext_data;    // extension bytes, last byte low, first of two high
        // registered outputs
        logic                 o_valid;
        logic                 o_page2;
        logic [7:0]           o_opcode;
        logic                 o_has_pb;
        logic [7:0]           o_postbyte;
        ipd_pkg::ipd_form_t   o_form;
        ipd_pkg::ipd_base_t   o_base;
        ipd_pkg::ipd_acc_t    o_accum;
        logic                 o_upd_post;
        logic [15:0]          o_offset;
        logic [1:0]           o_ext_count;
        logic [15:0]          o_ext_data;
    } ipd_dec_state_t;

    ipd_dec_state_t s_r;    // registered state
    ipd_dec_state_t s_nxt;  // next state

    // ------------------------------------------------------------------
    // postbyte classifier
    // ------------------------------------------------------------------
    ipd_pb_if pb_bus ();   // incoming byte seen as a postbyte

    ipd_pb_class u_pb_class (
        .pb (pb_bus.classifier)
    );

    // the classifier always looks at the current byte; only used in IPD_ST_POST
    assign pb_bus.index_postbyte = byte_data;

    // ------------------------------------------------------------------
    // stream handshake and lookup
    // ------------------------------------------------------------------
    // the parser never stalls; the output is a one-cycle pulse, so the
    // consumer must take it in the cycle it appears
    assign byte_ready    = ~rst;
    assign lookup_opcode = byte_data;
    assign lookup_page2  = s_r.page2;

    wire take = byte_valid & byte_ready;  // a byte is taken this edge

    // ------------------------------------------------------------------
    // final offset of a finished instruction
    // ------------------------------------------------------------------
    // assembled from the latched form and the extension bytes
    function automatic logic [15:0] final_offset(input ipd_dec_state_t s,
                                                 input logic [15:0] ext);
        logic [15:0] r;
        r = '0;
        case (s.form)
            ipd_pkg::IPD_FORM_CONST5: r = s.short_off;
            ipd_pkg::IPD_FORM_AUTO:   r = s.short_off;
            ipd_pkg::IPD_FORM_OFF9:   r = {{8{s.sign9}}, ext[7:0]};
            ipd_pkg::IPD_FORM_OFF16:  r = ext;
            ipd_pkg::IPD_FORM_IND16:  r = ext;
            default:                  r = '0;  // accumulator forms: offset from A/B/D
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic        finish;       // instruction completes this cycle
        logic [15:0] ext_now;      // extension data including this byte
        finish  = 1'b0;
        ext_now = s_r.ext_data;
        s_nxt   = s_r;
        s_nxt.o_valid = 1'b0;
        if (take) begin
            case (s_r.st)
                ipd_pkg::IPD_ST_OPCODE: begin
                    if (byte_data == ipd_pkg::PAGE2_PREFIX && !s_r.page2) begin
                        // prefix: next byte is a second page opcode
                        s_nxt.page2 = 1'b1;
                    end else begin
                        s_nxt.opcode    = byte_data;
                        s_nxt.pbkind    = lookup_pbkind;
                        s_nxt.op_ext    = lookup_ext_count;
                        s_nxt.postbyte  = '0;
                        s_nxt.form      = ipd_pkg::IPD_FORM_NONE;
                        s_nxt.base      = ipd_pkg::IPD_BASE_X;
                        s_nxt.accum     = ipd_pkg::IPD_ACC_A;
                        s_nxt.upd_post  = 1'b0;
                        s_nxt.sign9     = 1'b0;
                        s_nxt.short_off = '0;
                        s_nxt.ext_data  = '0;
                        ext_now         = '0;
                        if (lookup_pbkind != ipd_pkg::IPD_PB_NONE) begin
                            s_nxt.st = ipd_pkg::IPD_ST_POST;
                        end else if (lookup_ext_count != ipd_pkg::EXT_NONE) begin
                            s_nxt.ext_total = lookup_ext_count;
                            s_nxt.ext_left  = lookup_ext_count;
                            s_nxt.st        = ipd_pkg::IPD_ST_EXT;
                        end else begin
                            s_nxt.ext_total = ipd_pkg::EXT_NONE;
                            finish          = 1'b1;
                        end
                    end
                end
                ipd_pkg::IPD_ST_POST: begin
                    s_nxt.postbyte = byte_data;
                    if (s_r.pbkind == ipd_pkg::IPD_PB_INDEXED) begin
                        // indexed: extension count follows from the form
                        s_nxt.form      = pb_bus.form;
                        s_nxt.base      = pb_bus.base_reg_select;
                        s_nxt.accum     = pb_bus.accum_select;
                        s_nxt.upd_post  = pb_bus.update_post;
                        s_nxt.sign9     = pb_bus.sign9;
                        s_nxt.short_off = pb_bus.short_offset;
                        s_nxt.ext_total = pb_bus.ext_count;
                        s_nxt.ext_left  = pb_bus.ext_count;
                    end else begin
                        // transfer, exchange, loop: count from the opcode
                        s_nxt.ext_total = s_r.op_ext;
                        s_nxt.ext_left  = s_r.op_ext;
                    end
                    if (s_nxt.ext_left == ipd_pkg::EXT_NONE) begin
                        finish = 1'b1;
                    end else begin
                        s_nxt.st = ipd_pkg::IPD_ST_EXT;
                    end
                end
                ipd_pkg::IPD_ST_EXT: begin
                    // last extension byte ends up in the low half, the first of two in the high half
                    ext_now        = {s_r.ext_data[7:0], byte_data};
                    s_nxt.ext_data = ext_now;
                    s_nxt.ext_left = s_r.ext_left - 2'h1;
                    if (s_r.ext_left == ipd_pkg::EXT_ONE) begin
                        finish = 1'b1;
                    end
                end
                default: begin
                    // unreachable code space: resynchronise on an opcode
                    s_nxt.st = ipd_pkg::IPD_ST_OPCODE;
                end
            endcase
        end
        if (finish) begin
            // publish the instruction for exactly one cycle
            s_nxt.st          = ipd_pkg::IPD_ST_OPCODE;
            s_nxt.page2       = 1'b0;
            s_nxt.o_valid     = 1'b1;
            s_nxt.o_page2     = s_r.page2;
            s_nxt.o_opcode    = s_nxt.opcode;
            s_nxt.o_has_pb    = (s_nxt.pbkind != ipd_pkg::IPD_PB_NONE);
            s_nxt.o_postbyte  = s_nxt.postbyte;
            s_nxt.o_form      = s_nxt.form;
            s_nxt.o_base      = s_nxt.base;
            s_nxt.o_accum     = s_nxt.accum;
            s_nxt.o_upd_post  = s_nxt.upd_post;
            s_nxt.o_offset    = final_offset(s_nxt, ext_now);
            s_nxt.o_ext_count = s_nxt.ext_total;
            s_nxt.o_ext_data  = ext_now;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // synchronous reset drops any partial instruction
    always_ff @(posedge clk) begin
        if (rst) begin
            s_r    <= '0;
            s_r.st <= ipd_pkg::IPD_ST_OPCODE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign instr_valid        = s_r.o_valid;
    assign instr_page2        = s_r.o_page2;
    assign instr_opcode       = s_r.o_opcode;
    assign instr_has_postbyte = s_r.o_has_pb;
    assign instr_postbyte     = s_r.o_postbyte;
    assign instr_form         = s_r.o_form;
    assign instr_base         = s_r.o_base;
    assign instr_accum        = s_r.o_accum;
    assign instr_update_post  = s_r.o_upd_post;
    assign instr_offset       = s_r.o_offset;
    assign instr_ext_count    = s_r.o_ext_count;
    assign instr_ext_data     = s_r.o_ext_data;

endmodule // ipd_decoder

/* hdl/ipd_pkg.sv */
// shared constants and types for the indexed postbyte decoder
package ipd_pkg;

    // ------------------------------------------------------------------
    // stream bytes
    // ------------------------------------------------------------------
    localparam logic [7:0] PAGE2_PREFIX     = 8'h18;  // second opcode page prefix
    localparam int         BYTE_W           = 8;      // opcode, postbyte, extension width
    localparam int         WORD_W           = 16;     // offsets, addresses, immediates

    // ------------------------------------------------------------------
    // postbyte field positions
    // ------------------------------------------------------------------
    localparam int         PB_HI_RR_MSB     = 7;      // base field of short forms
    localparam int         PB_HI_RR_LSB     = 6;
    localparam int         PB_MID_RR_MSB    = 4;      // base field of 111rr forms
    localparam int         PB_MID_RR_LSB    = 3;
    localparam int         PB_AUTO_BIT      = 5;      // 0: constant offset, 1: auto or 111
    localparam int         PB_PRE_POST_BIT  = 4;      // 0: pre update, 1: post update
    localparam int         PB_ACC_BIT       = 2;      // in 111rr forms: 1 selects accumulator
    localparam int         PB_Z_BIT         = 1;
    localparam int         PB_S_BIT         = 0;
    localparam logic [2:0] PB_LONG_TAG      = 3'h7;   // top three bits of 111rr forms
    localparam logic [1:0] BASE_PC          = 2'h3;   // program counter encoding

    // ------------------------------------------------------------------
    // extension byte counts
    // ------------------------------------------------------------------
    localparam logic [1:0] EXT_NONE         = 2'h0;
    localparam logic [1:0] EXT_ONE          = 2'h1;
    localparam logic [1:0] EXT_TWO          = 2'h2;

    // base register encoding
    typedef enum logic [1:0] {
        IPD_BASE_X  = 2'b00,
        IPD_BASE_Y  = 2'b01,
        IPD_BASE_SP = 2'b10,
        IPD_BASE_PC = 2'b11
    } ipd_base_t;

    // accumulator choice of the accumulator offset forms
    typedef enum logic [1:0] {
        IPD_ACC_A    = 2'b00,
        IPD_ACC_B    = 2'b01,
        IPD_ACC_D    = 2'b10,
        IPD_ACC_DIND = 2'b11
    } ipd_acc_t;

    // decoded indexed form
    typedef enum logic [2:0] {
        IPD_FORM_NONE   = 3'b000,
        IPD_FORM_CONST5 = 3'b001,
        IPD_FORM_OFF9   = 3'b010,
        IPD_FORM_OFF16  = 3'b011,
        IPD_FORM_IND16  = 3'b100,
        IPD_FORM_AUTO   = 3'b101,
        IPD_FORM_ACC    = 3'b110,
        IPD_FORM_IND_D  = 3'b111
    } ipd_form_t;

    // what an opcode is followed by
    typedef enum logic [1:0] {
        IPD_PB_NONE    = 2'b00,
        IPD_PB_INDEXED = 2'b01,
        IPD_PB_OTHER   = 2'b10
    } ipd_pbkind_t;

    // stream parser states
    typedef enum logic [1:0] {
        IPD_ST_OPCODE = 2'b00,
        IPD_ST_POST   = 2'b01,
        IPD_ST_EXT    = 2'b10
    } ipd_state_t;

endpackage

/* hdl/ipd_pb_if.sv */
// carrier between the stream parser and the postbyte classifier
`timescale 1ns/10ps
interface ipd_pb_if;
    logic [7:0]         index_postbyte;   // postbyte under test
    ipd_pkg::ipd_form_t form;             // decoded indexed form
    ipd_pkg::ipd_base_t base_reg_select;  // chosen base register
    ipd_pkg::ipd_acc_t  accum_select;     // accumulator of the accumulator forms
    logic [15:0]        short_offset;     // sign extended 5-bit offset or auto step
    logic               update_post;      // auto form: update after use
    logic               sign9;            // ninth offset bit of the 9-bit form
    logic [1:0]         ext_count;        // extension bytes that follow

    modport classifier (
        input  index_postbyte,
        output form, base_reg_select, accum_select, short_offset,
        output update_post, sign9, ext_count
    );
    modport parser (
        output index_postbyte,
        input  form, base_reg_select, accum_select, short_offset,
        input  update_post, sign9, ext_count
    );
endinterface

/* hdl/ipd_pb_class.sv */
// combinational classifier of one indexed postbyte
`timescale 1ns/10ps
module ipd_pb_class (
    // postbyte in, fields out
    ipd_pb_if.classifier pb
);

    // ------------------------------------------------------------------
    // form decode
    // ------------------------------------------------------------------
    // pure decode; the parser registers whatever it keeps
    always_comb begin
        logic [7:0] b;
        b                  = pb.index_postbyte;
        pb.form            = ipd_pkg::IPD_FORM_CONST5;
        pb.base_reg_select = ipd_pkg::ipd_base_t'(b[ipd_pkg::PB_HI_RR_MSB:ipd_pkg::PB_HI_RR_LSB]);
        pb.accum_select    = ipd_pkg::ipd_acc_t'(b[1:0]);
        pb.short_offset    = {{11{b[4]}}, b[4:0]};
        pb.update_post     = b[ipd_pkg::PB_PRE_POST_BIT];
        pb.sign9           = b[ipd_pkg::PB_S_BIT];
        pb.ext_count       = ipd_pkg::EXT_NONE;
        if (b[ipd_pkg::PB_AUTO_BIT] == 1'b0) begin
            // rr0nnnnn: short signed constant, no extension
            pb.form = ipd_pkg::IPD_FORM_CONST5;
        end else if (b[7:5] == ipd_pkg::PB_LONG_TAG) begin
            // 111rr...: base field moves to bits 4:3
            pb.base_reg_select =
                ipd_pkg::ipd_base_t'(b[ipd_pkg::PB_MID_RR_MSB:ipd_pkg::PB_MID_RR_LSB]);
            pb.short_offset = '0;
            if (b[ipd_pkg::PB_ACC_BIT]) begin
                // accumulator offset, aa = 11 is the D indirect form
                if (b[1:0] == 2'h3) begin
                    pb.form = ipd_pkg::IPD_FORM_IND_D;
                end else begin
                    pb.form = ipd_pkg::IPD_FORM_ACC;
                end
            end else if (!b[ipd_pkg::PB_Z_BIT]) begin
                pb.form      = ipd_pkg::IPD_FORM_OFF9;
                pb.ext_count = ipd_pkg::EXT_ONE;
            end else if (!b[ipd_pkg::PB_S_BIT]) begin
                pb.form      = ipd_pkg::IPD_FORM_OFF16;
                pb.ext_count = ipd_pkg::EXT_TWO;
            end else begin
                // z = s = 1 is never a plain offset
                pb.form      = ipd_pkg::IPD_FORM_IND16;
                pb.ext_count = ipd_pkg::EXT_TWO;
            end
        end else begin
            // rr1pnnnn with rr != 11: PC can never land here
            pb.form = ipd_pkg::IPD_FORM_AUTO;
            if (b[3]) begin
                pb.short_offset = {{12{1'b1}}, b[3:0]};                   // -8 .. -1
            end else begin
                pb.short_offset = {12'h000, b[3:0] + 4'h1};               // +1 .. +8
            end
        end
    end

endmodule // ipd_pb_class

/* bench/ipd_optable_model.sv */
// opcode table model standing in for the fetch side lookup
`timescale 1ns/10ps
module ipd_optable_model (
    // lookup request
    input  wire logic [7:0]      lookup_opcode,
    input  wire logic            lookup_page2,
    // classification answer
    output ipd_pkg::ipd_pbkind_t lookup_pbkind,
    output logic [1:0]           lookup_ext_count
);
    // ----------------------------------------------------------------
    // invented map, shared by both pages
    // ----------------------------------------------------------------
    always_comb begin
        lookup_pbkind    = ipd_pkg::IPD_PB_NONE;
        lookup_ext_count = 2'h0;
        case (lookup_opcode)
            8'ha6: lookup_pbkind = ipd_pkg::IPD_PB_INDEXED;  // indexed op
            8'hb7: lookup_pbkind = ipd_pkg::IPD_PB_OTHER;    // transfer style op
            8'h04: begin
                lookup_pbkind    = ipd_pkg::IPD_PB_OTHER;    // loop style op
                lookup_ext_count = 2'h1;                     // relative byte
            end
            8'h86: lookup_ext_count = 2'h1;                  // immediate byte
            default: lookup_ext_count = 2'h0;                // inherent
        endcase
    end
endmodule // ipd_optable_model

/* bench/ipd_decoder_properties.sv */
// concurrent checks on the decoder ports
`timescale 1ns/10ps
module ipd_decoder_chk (
    // clock and reset
    input wire logic               clk,
    input wire logic               rst,
    // stream side
    input wire logic               byte_valid,
    input wire logic [7:0]         byte_data,
    input wire logic               byte_ready,
    input wire logic               lookup_page2,
    // decoded instruction
    input wire logic               instr_valid,
    input wire logic [7:0]         instr_postbyte,
    input wire ipd_pkg::ipd_form_t instr_form,
    input wire ipd_pkg::ipd_base_t instr_base,
    input wire ipd_pkg::ipd_acc_t  instr_accum,
    input wire logic               instr_update_post,
    input wire logic [15:0]        instr_offset,
    input wire logic [1:0]         instr_ext_count,
    input wire logic [15:0]        instr_ext_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [7:0] pb;   // short alias of the taken postbyte
    assign pb = instr_postbyte;
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_ready_follows_rst: assert property (disable iff (1'b0) byte_ready == !rst)
        else $error("byte_ready does not follow reset");
    a_valid_after_byte: assert property (instr_valid |-> $past(byte_valid))
        else $error("instr_valid without a taken byte");
    a_page_prefix: assert property ($rose(lookup_page2) |->
        $past(byte_data) == ipd_pkg::PAGE2_PREFIX) else $error("page2 without prefix");
    a_const5_offset: assert property (
        instr_valid && instr_form == ipd_pkg::IPD_FORM_CONST5
        |-> !pb[5] && instr_offset == {{11{pb[4]}}, pb[4:0]} && instr_ext_count == 2'h0
        && instr_base == pb[7:6]) else $error("bad 5-bit offset decode");
    a_auto_step: assert property (
        instr_valid && instr_form == ipd_pkg::IPD_FORM_AUTO |->
        pb[5] && pb[7:6] != 2'h3 && instr_update_post == pb[4] && instr_ext_count == 2'h0
        && instr_offset == (pb[3] ? {12'hfff, pb[3:0]} : {12'h000, pb[3:0]} + 16'h0001))
        else $error("bad auto update decode");
    a_off9_ext: assert property (
        instr_valid && instr_form == ipd_pkg::IPD_FORM_OFF9 |->
        instr_ext_count == 2'h1 && instr_offset == {{8{pb[0]}}, instr_ext_data[7:0]})
        else $error("bad 9-bit offset");
    a_off16_ext: assert property (instr_valid && (instr_form == ipd_pkg::IPD_FORM_OFF16
        || instr_form == ipd_pkg::IPD_FORM_IND16) |-> instr_ext_count == 2'h2
        && instr_offset == instr_ext_data && pb[1]) else $error("bad 16-bit offset");
    a_long_form: assert property (
        instr_valid && instr_form != ipd_pkg::IPD_FORM_NONE
        && pb[7:5] == 3'h7 |-> instr_base == pb[4:3] && instr_form == (pb[2] ?
        (pb[1:0] == 2'h3 ? ipd_pkg::IPD_FORM_IND_D : ipd_pkg::IPD_FORM_ACC) :
        (pb[1:0] == 2'h3 ? ipd_pkg::IPD_FORM_IND16 : pb[1] ? ipd_pkg::IPD_FORM_OFF16 :
        ipd_pkg::IPD_FORM_OFF9))) else $error("bad long form class");
    a_accum_select: assert property (
        instr_valid && (instr_form == ipd_pkg::IPD_FORM_ACC
        || instr_form == ipd_pkg::IPD_FORM_IND_D) |-> instr_accum == pb[1:0]
        && instr_ext_count == 2'h0) else $error("bad accumulator choice");
endmodule // ipd_decoder_chk
bind ipd_decoder ipd_decoder_chk u_chk (.clk(clk), .rst(rst), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready(byte_ready), .lookup_page2(lookup_page2),
    .instr_valid(instr_valid), .instr_postbyte(instr_postbyte), .instr_form(instr_form),
    .instr_base(instr_base), .instr_accum(instr_accum), .instr_offset(instr_offset),
    .instr_update_post(instr_update_post), .instr_ext_count(instr_ext_count),
    .instr_ext_data(instr_ext_data));

/* bench/ipd_decoder_tb_top.sv */
// self-checking bench for the decoder
`timescale 1ns/10ps
module ipd_decoder_tb_top;
    logic clk, rst, byte_valid, byte_ready, lookup_page2, instr_valid, instr_page2;
    logic instr_has_postbyte, instr_update_post;
    logic [7:0] byte_data, lookup_opcode, instr_opcode, instr_postbyte;
    logic [1:0] lookup_ext_count, instr_ext_count;
    logic [15:0] instr_offset, instr_ext_data;
    ipd_pkg::ipd_pbkind_t lookup_pbkind;
    ipd_pkg::ipd_form_t instr_form;
    ipd_pkg::ipd_base_t instr_base;
    ipd_pkg::ipd_acc_t instr_accum;
    int bad_count = 0;   // mismatches seen
    int n_compared = 0;  // comparisons made
    ipd_decoder dut (.*);
    ipd_optable_model u_tab (.lookup_opcode(lookup_opcode), .lookup_page2(lookup_page2),
        .lookup_pbkind(lookup_pbkind), .lookup_ext_count(lookup_ext_count));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one byte per cycle; idle byte is a prefix value to show it is ignored
    task automatic feed(input logic [7:0] b[$]);
        foreach (b[i]) begin
            @(posedge clk);
            byte_valid <= 1'b1;
            byte_data  <= b[i];
        end
        @(posedge clk);
        byte_valid <= 1'b0;
        byte_data  <= ipd_pkg::PAGE2_PREFIX;
        #1 chk(16'(instr_valid), 16'h0001, "valid");
    endtask
    task automatic chk_ix(input logic [2:0] f, input logic [1:0] b, input logic [15:0] o,
                          input logic [1:0] n);
        chk(16'(instr_form), 16'(f), "form");
        chk(16'(instr_base), 16'(b), "base");
        chk(instr_offset, o, "offset");
        chk(16'(instr_ext_count), 16'(n), "ext count");
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_short();
        feed({8'ha6, 8'h0f});
        chk_ix(3'h1, 2'h0, 16'h000f, 2'h0);
        chk(16'(instr_page2), 16'h0000, "page2");
        feed({8'ha6, 8'h50});
        chk_ix(3'h1, 2'h1, 16'hfff0, 2'h0);
        feed({8'ha6, 8'h27});
        chk_ix(3'h5, 2'h0, 16'h0008, 2'h0);
        chk(16'(instr_update_post), 16'h0000, "pre");
        feed({8'ha6, 8'hb8});
        chk_ix(3'h5, 2'h2, 16'hfff8, 2'h0);
        chk(16'(instr_update_post), 16'h0001, "post");
    endtask
    task automatic t_ext();
        feed({8'ha6, 8'he9, 8'h80});
        chk_ix(3'h2, 2'h1, 16'hff80, 2'h1);
        feed({8'ha6, 8'hf2, 8'h12, 8'h34});
        chk_ix(3'h3, 2'h2, 16'h1234, 2'h2);
        feed({8'ha6, 8'hfb, 8'hab, 8'hcd});
        chk_ix(3'h4, 2'h3, 16'habcd, 2'h2);
        chk(instr_ext_data, 16'habcd, "ext data");
    endtask
    task automatic t_acc();
        for (int a = 0; a < 4; a++) begin
            feed({8'ha6, 8'hfc + 8'(a)});
            chk_ix((a == 3) ? 3'h7 : 3'h6, 2'h3, 16'h0000, 2'h0);
            chk(16'(instr_accum), 16'(a), "accum");
        end
    endtask
    task automatic t_stream();
        feed({8'hb7, 8'h3c});
        chk(16'(instr_has_postbyte), 16'h0001, "has pb");
        chk({8'h00, instr_postbyte}, 16'h003c, "pb");
        chk(16'(instr_form), 16'h0000, "form");
        feed({8'h18, 8'h86, 8'h5a});
        chk({7'h00, instr_page2, instr_opcode}, 16'h0186, "page2 op");
        chk(instr_ext_data, 16'h005a, "ext data");
        chk(16'(instr_has_postbyte), 16'h0000, "no pb");
        feed({8'h04, 8'h20, 8'hfe});
        chk({6'h00, instr_ext_count, instr_postbyte}, 16'h0120, "loop pb");
        chk(instr_ext_data, 16'h00fe, "loop ext");
        feed({8'h18, 8'h18});
        chk({7'h00, instr_page2, instr_opcode}, 16'h0118, "page2 18");
    endtask
    // reset after an opcode must drop the pending postbyte
    task automatic t_reset();
        @(posedge clk);
        byte_valid <= 1'b1;
        byte_data  <= 8'ha6;
        @(posedge clk);
        rst        <= 1'b1;
        byte_valid <= 1'b0;
        @(posedge clk);
        rst        <= 1'b0;
        #1 chk(16'(instr_valid), 16'h0000, "valid in reset");
        feed({8'h0f});
        chk({7'h00, instr_has_postbyte, instr_opcode}, 16'h000f, "after rst");
    endtask
    initial begin
        rst        = 1'b1;
        byte_valid = 1'b0;
        byte_data  = 8'h00;
        repeat (8) @(posedge clk);
        chk(16'(byte_ready), 16'h0000, "ready in reset");
        rst <= 1'b0;
        #1 chk(16'(byte_ready), 16'h0001, "ready");
        t_short();
        t_ext();
        t_acc();
        t_stream();
        t_reset();
        conclude();
    end
    initial begin
        #20000;
        bad_count++;
        conclude();
    end
endmodule // ipd_decoder_tb_top
